// >>> shared/rtdm_pkg.sv
// constants and types shared by the rtd input data map
package rtdm_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_CH  = 7;                    // measured channels
  localparam int NUM_ENT = 8;                    // channels plus average
  localparam int DW      = 16;                   // value width
  localparam int SUM_W   = 19;                   // width of seven-value sum
  localparam logic [2:0] AVG_ENT = 3'h7;         // tracker index of average

  // ****************************************************************
  // coil (0x) space, address of slot 0 of each group
  // ****************************************************************
  localparam logic [15:0] COIL_MAX_RST_BASE = 16'h0065; // 00101
  localparam logic [15:0] COIL_MIN_RST_BASE = 16'h006f; // 00111
  localparam logic [15:0] COIL_BURNOUT_BASE = 16'h0079; // 00121
  localparam logic [15:0] COIL_HI_ALM_BASE  = 16'h0083; // 00131
  localparam logic [15:0] COIL_LO_ALM_BASE  = 16'h008d; // 00141

  // ****************************************************************
  // register (4x) space
  // ****************************************************************
  localparam logic [15:0] REG_MEAS_BASE     = 16'h9c41; // 40001
  localparam logic [15:0] REG_MAX_BASE      = 16'h9c4b; // 40011
  localparam logic [15:0] REG_MIN_BASE      = 16'h9c55; // 40021
  localparam logic [15:0] REG_LOGIC_FLAGS   = 16'h9d71; // 40305

  // ****************************************************************
  // slot layout inside a group
  // ****************************************************************
  localparam logic [15:0] GROUP_SPAN   = 16'h0009;  // slots 0..8
  localparam logic [15:0] BURNOUT_SPAN = 16'h0007;  // slots 0..6
  localparam logic [15:0] RSVD_SLOT    = 16'h0007;  // unused eighth slot
  localparam logic [15:0] AVG_SLOT     = 16'h0008;  // average slot

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] MEAS_RST  = 16'h0000;
  localparam logic [15:0] MAX_RST   = 16'h0000;
  localparam logic [15:0] MIN_RST   = 16'hffff;
  localparam logic [15:0] FLAGS_RST = 16'h0000;

  // response status of an access
  typedef enum logic [1:0] {
    RSP_OK       = 2'b00,
    RSP_READONLY = 2'b01,
    RSP_UNMAPPED = 2'b10
  } rtdm_rsp_type;

endpackage : rtdm_pkg

// >>> shared/rtdm_trk_if.sv
// link between the map and one max/min/alarm tracker
`timescale 1ns/1ps
`default_nettype none
interface rtdm_trk_if;
  logic        sample;       // new value present, one cycle
  logic        restart_max;  // restart max tracking, one cycle
  logic        restart_min;  // restart min tracking, one cycle
  logic [15:0] value;        // current value
  logic [15:0] hi_thr;       // high alarm threshold
  logic [15:0] lo_thr;       // low alarm threshold
  logic [15:0] max_val;      // tracked maximum
  logic [15:0] min_val;      // tracked minimum
  logic        hi_alarm;     // value above high threshold
  logic        lo_alarm;     // value below low threshold

  modport ctrl (output sample, restart_max, restart_min, value, hi_thr, lo_thr,
                input  max_val, min_val, hi_alarm, lo_alarm);
  modport trk  (input  sample, restart_max, restart_min, value, hi_thr, lo_thr,
                output max_val, min_val, hi_alarm, lo_alarm);
endinterface : rtdm_trk_if
`default_nettype wire

// >>> tb/rtdm_client.sv
// client model that issues single accesses to the map
`timescale 1ns/1ps
`default_nettype none
module rtdm_client
  import rtdm_pkg::*;
(
  // clock
  input  wire logic         i_mclk,
  // request
  output var logic          o_acc_valid,
  output var logic          o_acc_coil,
  output var logic          o_acc_write,
  output var logic [15:0]   o_acc_addr,
  output var logic [15:0]   o_acc_wdata,
  // answer
  input  wire logic         i_rsp_valid,
  input  wire logic [15:0]  i_rsp_rdata,
  input  wire rtdm_rsp_type i_rsp_status
);
  // idle request lines at time zero
  initial begin
    o_acc_valid = 1'b0;
    o_acc_coil  = 1'b0;
    o_acc_write = 1'b0;
    o_acc_addr  = 16'h0;
    o_acc_wdata = 16'h0;
  end

  // one access, answer taken in the cycle it stands
  task automatic xfer(input logic c, w, input logic [15:0] a, d,
                      output logic [15:0] rd, output rtdm_rsp_type st, output logic to);
    int n;
    @(posedge i_mclk);
    o_acc_valid <= 1'b1;
    o_acc_coil  <= c;  // coil or register space
    o_acc_write <= w;
    o_acc_addr  <= a;
    o_acc_wdata <= d;  // coil on or off in bit 0
    @(posedge i_mclk);
    o_acc_valid <= 1'b0;
    o_acc_addr  <= ~a;  // released lines do not keep the old value
    o_acc_wdata <= ~d;
    n = 0;
    #1;
    while (i_rsp_valid !== 1'b1 && n < 4) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    to = (n == 4);
    rd = i_rsp_rdata;
    st = i_rsp_status;
  endtask : xfer
endmodule : rtdm_client
`default_nettype wire

// >>> tb/rtdm_map_tb_top.sv
// self-checking bench of the rtd input data map
`timescale 1ns/1ps
`default_nettype none
module rtdm_map_tb_top
  import rtdm_pkg::*;
;
  localparam logic [15:0] HI = 16'h001e;  // high threshold, all entries
  localparam logic [15:0] LO = 16'h0019;  // low threshold, all entries
  logic                  i_mclk, i_rst, i_meas_valid;
  logic [NUM_CH*DW-1:0]  i_meas_values;
  logic [NUM_CH-1:0]     i_burnout;
  logic [NUM_ENT*DW-1:0] i_high_thr, i_low_thr;
  logic                  i_acc_valid, i_acc_coil, i_acc_write, o_rsp_valid;
  logic [15:0]           i_acc_addr, i_acc_wdata, o_rsp_rdata, o_logic_rule_flags, rd;
  rtdm_rsp_type          o_rsp_status, st;
  logic                  to;
  logic [15:0]           cur[8], mx[8], mn[8];  // expected values and trackers
  int                    n_errors, checks_done;

  rtdm_map rtdm_map_i (.i_mclk, .i_rst, .i_meas_valid, .i_meas_values, .i_burnout,
    .i_high_thr, .i_low_thr, .i_acc_valid, .i_acc_coil, .i_acc_write, .i_acc_addr,
    .i_acc_wdata, .o_rsp_valid, .o_rsp_rdata, .o_rsp_status, .o_logic_rule_flags);
  rtdm_client rtdm_client_i (.i_mclk, .o_acc_valid(i_acc_valid), .o_acc_coil(i_acc_coil),
    .o_acc_write(i_acc_write), .o_acc_addr(i_acc_addr), .o_acc_wdata(i_acc_wdata),
    .i_rsp_valid(o_rsp_valid), .i_rsp_rdata(o_rsp_rdata), .i_rsp_status(o_rsp_status));

  // 200 mhz clock
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // access with hang guard
  task automatic ac(input logic c, w, input logic [15:0] a, d);
    rtdm_client_i.xfer(c, w, a, d, rd, st, to);
    if (to) begin
      n_errors++;
      wrap_up();
    end
  endtask : ac

  // expected content of slot s of group g, eighth slot zero
  function automatic logic [15:0] ex(int g, int s);
    int e;
    e = (s == 8) ? 7 : s;
    if (s == 7) return 16'h0;
    case (g)
      0: return cur[e];
      1: return mx[e];
      2: return mn[e];
      3: return {15'h0, cur[e] > HI};
      default: return {15'h0, cur[e] < LO};
    endcase
  endfunction : ex

  // read all nine slots of the first n groups
  task automatic grps(int n);
    logic [15:0] b[5] = '{REG_MEAS_BASE, REG_MAX_BASE, REG_MIN_BASE,
                          COIL_HI_ALM_BASE, COIL_LO_ALM_BASE};
    for (int g = 0; g < n; g++) begin
      for (int s = 0; s < 9; s++) begin
        ac(g > 2, 1'b0, b[g] + 16'(s), 16'h0);
        chk("slot", ex(g, s), rd);
        chk("slot status", 16'h0, {14'h0, st});
      end
    end
  endtask : grps

  // new channel values of step b, trackers updated in the model
  task automatic sample(input logic [15:0] b);
    logic [18:0] sum;
    sum = '0;
    @(posedge i_mclk);
    for (int k = 0; k < 7; k++) begin
      cur[k] = b * 16'(k + 1);
      i_meas_values[16*k +: 16] <= cur[k];
      sum += 19'(cur[k]);
    end
    cur[7] = 16'(sum / 19'd7);
    for (int e = 0; e < 8; e++) begin
      if (cur[e] > mx[e]) mx[e] = cur[e];
      if (cur[e] < mn[e]) mn[e] = cur[e];
    end
    i_meas_valid <= 1'b1;
    @(posedge i_mclk);
    i_meas_valid <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask : sample

  // main sequence
  initial begin
    i_rst = 1'b1;
    i_meas_valid = 1'b0;
    i_meas_values = '0;
    i_burnout = 7'h55;
    i_high_thr = {8{HI}};  // thresholds set before alarms are read
    i_low_thr = {8{LO}};
    n_errors = 0;
    checks_done = 0;
    foreach (cur[e]) begin
      cur[e] = 16'h0;
      mx[e] = MAX_RST;
      mn[e] = MIN_RST;
    end
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    grps(3);
    sample(16'h000a);
    grps(5);
    sample(16'h0005);
    grps(5);
    // every reset coil written on, then read back
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 9; s++) begin
        ac(1'b1, 1'b1, (b > 0 ? COIL_MIN_RST_BASE : COIL_MAX_RST_BASE) + 16'(s), 16'h1);
        ac(1'b1, 1'b0, (b > 0 ? COIL_MIN_RST_BASE : COIL_MAX_RST_BASE) + 16'(s), 16'h0);
        chk("reset coil", (s == 7) ? 16'h0 : 16'h1, rd);
      end
    end
    foreach (cur[e]) begin
      mx[e] = cur[e];
      mn[e] = cur[e];
    end
    sample(16'h0008);
    grps(3);
    for (int s = 0; s < 9; s++) begin
      ac(1'b1, 1'b0, COIL_BURNOUT_BASE + 16'(s), 16'h0);
      chk("burnout", (s < 7) ? {15'h0, i_burnout[s]} : 16'h0, rd);
      chk("burnout status", (s < 7) ? 16'h0 : 16'h2, {14'h0, st});
    end
    ac(1'b0, 1'b1, REG_MEAS_BASE, 16'h1234);
    chk("value write status", 16'h1, {14'h0, st});
    ac(1'b0, 1'b1, REG_MAX_BASE, 16'h1234);
    chk("max write status", 16'h1, {14'h0, st});
    ac(1'b1, 1'b1, COIL_HI_ALM_BASE + 16'h6, 16'h0);
    chk("alarm write status", 16'h1, {14'h0, st});
    grps(4);
    ac(1'b0, 1'b1, REG_LOGIC_FLAGS, 16'ha5c3);
    ac(1'b0, 1'b0, REG_LOGIC_FLAGS, 16'h0);
    chk("flag word", 16'ha5c3, rd);
    chk("flag output", 16'ha5c3, o_logic_rule_flags);
    ac(1'b0, 1'b0, 16'h9c40, 16'h0);
    chk("unmapped status", 16'h2, {14'h0, st});
    wrap_up();
  end
endmodule : rtdm_map_tb_top
`default_nettype wire

// >>> verilog/rtdm_map.sv
// data map of the seven-channel rtd input: values, trackers, coils, flags
//
// How it works
// RULE_01: channel values and average readable, read-only
// RULE_02: historical maximum per channel and average
// RULE_03: historical minimum per channel and average
// RULE_04: max reset coils restart maximum tracking
// RULE_05: min reset coils restart minimum tracking
// RULE_06: burnout coil reads one without sensor
// RULE_07: high alarm when value above threshold
// RULE_08: low alarm when value below threshold
// RULE_09: client sets thresholds before trusting alarms
// RULE_10: sixteen-bit logic flag word, read and write
// RULE_11: eighth slots read zero, ignore writes
// RULE_12: writes to read-only items are refused
// RULE_13: client forces single coils on or off
// RULE_14: registers read back binary contents
// RULE_15: coils read back as single bits
`timescale 1ns/1ps
`default_nettype none
module rtdm_map
  import rtdm_pkg::*;
(
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst,
  // measurement side
  input  wire logic                    i_meas_valid,
  input  wire logic [NUM_CH*DW-1:0]    i_meas_values,
  input  wire logic [NUM_CH-1:0]       i_burnout,
  input  wire logic [NUM_ENT*DW-1:0]   i_high_thr,
  input  wire logic [NUM_ENT*DW-1:0]   i_low_thr,
  // map access
  input  wire logic                    i_acc_valid,
  input  wire logic                    i_acc_coil,
  input  wire logic                    i_acc_write,
  input  wire logic [15:0]             i_acc_addr,
  input  wire logic [15:0]             i_acc_wdata,
  // access answer
  output logic                         o_rsp_valid,
  output logic [15:0]                  o_rsp_rdata,
  output rtdm_rsp_type                 o_rsp_status,
  // logic rule engine flag word
  output logic [15:0]                  o_logic_rule_flags
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [DW-1:0]      meas_ff [NUM_ENT];     // values, entry 7 is average
  logic               sample_ff;             // trackers see new values
  logic [NUM_CH-1:0]  burnout_ff;            // burnout flags
  logic [NUM_ENT-1:0] max_coil_ff;           // max reset coils
  logic [NUM_ENT-1:0] min_coil_ff;           // min reset coils
  logic [NUM_ENT-1:0] max_pulse_ff;          // max restart strobes
  logic [NUM_ENT-1:0] min_pulse_ff;          // min restart strobes
  logic [DW-1:0]      flags_ff;              // logic rule flag word
  logic [SUM_W-1:0]   sum;                   // sum of channel inputs
  logic [15:0]        nxt_rdata;             // read data of this access
  rtdm_rsp_type       nxt_status;            // status of this access
  logic [NUM_ENT-1:0] hi_vec;                // gathered high alarms
  logic [NUM_ENT-1:0] lo_vec;                // gathered low alarms
  logic [DW-1:0]      max_vec [NUM_ENT];     // gathered maxima
  logic [DW-1:0]      min_vec [NUM_ENT];     // gathered minima

  // whether an address lies inside a group of span slots
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b,
                               input logic [15:0] span);
    hit = (a >= b) && (a - b < span);
  endfunction : hit

  // entry index of a slot, avg slot folds onto entry 7
  function automatic logic [2:0] ent(input logic [15:0] slot);
    ent = (slot == AVG_SLOT) ? AVG_ENT : slot[2:0];
  endfunction : ent

  // ****************************************************************
  // channel sum for the average
  // ****************************************************************
  always_comb begin
    sum = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      sum = sum + SUM_W'(i_meas_values[i*DW +: DW]);
    end
  end

  // ****************************************************************
  // measured values and average capture
  // ****************************************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_ENT; i++) begin
        meas_ff[i] <= MEAS_RST;
      end
      sample_ff <= 1'b0;
    end else begin
      sample_ff <= i_meas_valid;
      if (i_meas_valid) begin                        // [RULE_01]
        for (int i = 0; i < NUM_CH; i++) begin
          meas_ff[i] <= i_meas_values[i*DW +: DW];
        end
        meas_ff[NUM_CH] <= DW'(sum / SUM_W'(NUM_CH));
      end
    end
  end

  // ****************************************************************
  // burnout flags follow the detector
  // ****************************************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      burnout_ff <= '0;
    end else begin
      burnout_ff <= i_burnout;                       // [RULE_06]
    end
  end

  // ****************************************************************
  // coil and flag word writes, restart strobes
  // ****************************************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      max_coil_ff  <= '0;
      min_coil_ff  <= '0;
      max_pulse_ff <= '0;
      min_pulse_ff <= '0;
      flags_ff     <= FLAGS_RST;
    end else begin
      max_pulse_ff <= '0;
      min_pulse_ff <= '0;
      if (i_acc_valid && i_acc_write) begin
        if (i_acc_coil && hit(i_acc_addr, COIL_MAX_RST_BASE, GROUP_SPAN)
            && (i_acc_addr - COIL_MAX_RST_BASE) != RSVD_SLOT) begin
          max_coil_ff[ent(i_acc_addr - COIL_MAX_RST_BASE)]  <= i_acc_wdata[0];
          max_pulse_ff[ent(i_acc_addr - COIL_MAX_RST_BASE)] <= i_acc_wdata[0]; // [RULE_04]
        end else if (i_acc_coil && hit(i_acc_addr, COIL_MIN_RST_BASE, GROUP_SPAN)
                     && (i_acc_addr - COIL_MIN_RST_BASE) != RSVD_SLOT) begin
          min_coil_ff[ent(i_acc_addr - COIL_MIN_RST_BASE)]  <= i_acc_wdata[0];
          min_pulse_ff[ent(i_acc_addr - COIL_MIN_RST_BASE)] <= i_acc_wdata[0]; // [RULE_05]
        end else if (!i_acc_coil && i_acc_addr == REG_LOGIC_FLAGS) begin
          flags_ff <= i_acc_wdata;                   // [RULE_10]
        end
      end
    end
  end

  // ****************************************************************
  // one tracker per entry
  // ****************************************************************
  for (genvar g = 0; g < NUM_ENT; g++) begin : g_trk
    rtdm_trk_if trk_if ();
    assign trk_if.sample      = sample_ff;
    assign trk_if.restart_max = max_pulse_ff[g];
    assign trk_if.restart_min = min_pulse_ff[g];
    assign trk_if.value       = meas_ff[g];
    assign trk_if.hi_thr      = i_high_thr[g*DW +: DW];  // [RULE_09]
    assign trk_if.lo_thr      = i_low_thr[g*DW +: DW];
    assign max_vec[g]         = trk_if.max_val;
    assign min_vec[g]         = trk_if.min_val;
    assign hi_vec[g]          = trk_if.hi_alarm;
    assign lo_vec[g]          = trk_if.lo_alarm;
    rtdm_tracker u_trk (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .trk    (trk_if.trk)
    );
  end

  // ****************************************************************
  // read decode and write refusal
  // ****************************************************************
  always_comb begin
    nxt_rdata  = 16'h0000;
    nxt_status = RSP_OK;
    if (i_acc_coil) begin                            // coils in bit 0 [RULE_15]
      if (hit(i_acc_addr, COIL_MAX_RST_BASE, GROUP_SPAN)) begin
        if ((i_acc_addr - COIL_MAX_RST_BASE) != RSVD_SLOT) begin // [RULE_11]
          nxt_rdata[0] = max_coil_ff[ent(i_acc_addr - COIL_MAX_RST_BASE)];
        end
      end else if (hit(i_acc_addr, COIL_MIN_RST_BASE, GROUP_SPAN)) begin
        if ((i_acc_addr - COIL_MIN_RST_BASE) != RSVD_SLOT) begin
          nxt_rdata[0] = min_coil_ff[ent(i_acc_addr - COIL_MIN_RST_BASE)];
        end
      end else if (hit(i_acc_addr, COIL_BURNOUT_BASE, BURNOUT_SPAN)) begin
        nxt_rdata[0] = burnout_ff[ent(i_acc_addr - COIL_BURNOUT_BASE)]; // [RULE_06]
        nxt_status   = i_acc_write ? RSP_READONLY : RSP_OK;             // [RULE_12]
      end else if (hit(i_acc_addr, COIL_HI_ALM_BASE, GROUP_SPAN)) begin
        if ((i_acc_addr - COIL_HI_ALM_BASE) != RSVD_SLOT) begin
          nxt_rdata[0] = hi_vec[ent(i_acc_addr - COIL_HI_ALM_BASE)];    // [RULE_07]
          nxt_status   = i_acc_write ? RSP_READONLY : RSP_OK;
        end
      end else if (hit(i_acc_addr, COIL_LO_ALM_BASE, GROUP_SPAN)) begin
        if ((i_acc_addr - COIL_LO_ALM_BASE) != RSVD_SLOT) begin
          nxt_rdata[0] = lo_vec[ent(i_acc_addr - COIL_LO_ALM_BASE)];    // [RULE_08]
          nxt_status   = i_acc_write ? RSP_READONLY : RSP_OK;
        end
      end else begin
        nxt_status = RSP_UNMAPPED;
      end
    end else begin                                   // binary words [RULE_14]
      if (hit(i_acc_addr, REG_MEAS_BASE, GROUP_SPAN)) begin
        if ((i_acc_addr - REG_MEAS_BASE) != RSVD_SLOT) begin
          nxt_rdata  = meas_ff[ent(i_acc_addr - REG_MEAS_BASE)];        // [RULE_01]
          nxt_status = i_acc_write ? RSP_READONLY : RSP_OK;
        end
      end else if (hit(i_acc_addr, REG_MAX_BASE, GROUP_SPAN)) begin
        if ((i_acc_addr - REG_MAX_BASE) != RSVD_SLOT) begin
          nxt_rdata  = max_vec[ent(i_acc_addr - REG_MAX_BASE)];         // [RULE_02]
          nxt_status = i_acc_write ? RSP_READONLY : RSP_OK;
        end
      end else if (hit(i_acc_addr, REG_MIN_BASE, GROUP_SPAN)) begin
        if ((i_acc_addr - REG_MIN_BASE) != RSVD_SLOT) begin
          nxt_rdata  = min_vec[ent(i_acc_addr - REG_MIN_BASE)];         // [RULE_03]
          nxt_status = i_acc_write ? RSP_READONLY : RSP_OK;
        end
      end else if (i_acc_addr == REG_LOGIC_FLAGS) begin
        nxt_rdata = flags_ff;                                           // [RULE_10]
      end else begin
        nxt_status = RSP_UNMAPPED;
      end
    end
  end

  // ****************************************************************
  // answer registers, one cycle after the access
  // ****************************************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rsp_valid  <= 1'b0;
      o_rsp_rdata  <= 16'h0000;
      o_rsp_status <= RSP_OK;
    end else begin
      o_rsp_valid <= i_acc_valid;
      if (i_acc_valid) begin
        o_rsp_rdata  <= nxt_rdata;
        o_rsp_status <= nxt_status;
      end
    end
  end

  // flag word to the logic rule engine, registered one cycle behind flags_ff
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_logic_rule_flags <= FLAGS_RST;
    end else begin
      o_logic_rule_flags <= flags_ff;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_meas_read;
    @(posedge i_mclk) disable iff (i_rst)
    i_acc_valid && !i_acc_coil && i_acc_addr == REG_MEAS_BASE
      |=> o_rsp_valid && o_rsp_rdata == $past(meas_ff[0]);
  endproperty
  a_meas_read: assert property (p_meas_read) // [RULE_01]
    else $error("channel 0 value read wrong");

  property p_ro_refused;
    @(posedge i_mclk) disable iff (i_rst)
    i_acc_valid && i_acc_write && !i_acc_coil && i_acc_addr == REG_MAX_BASE
      |=> o_rsp_status == RSP_READONLY;
  endproperty
  a_ro_refused: assert property (p_ro_refused) // [RULE_12]
    else $error("write to read-only word not refused");

  property p_rsvd_zero;
    @(posedge i_mclk) disable iff (i_rst)
    i_acc_valid && !i_acc_coil && i_acc_addr == REG_MEAS_BASE + RSVD_SLOT
      |=> o_rsp_rdata == 16'h0000 && o_rsp_status == RSP_OK;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // [RULE_11]
    else $error("reserved slot not zero");

  property p_flags_rw;
    @(posedge i_mclk) disable iff (i_rst)
    i_acc_valid && i_acc_write && !i_acc_coil && i_acc_addr == REG_LOGIC_FLAGS
      |=> ##1 o_logic_rule_flags == $past(i_acc_wdata, 2);
  endproperty
  a_flags_rw: assert property (p_flags_rw) // [RULE_10]
    else $error("flag word not stored");

  property p_burnout_read;
    @(posedge i_mclk) disable iff (i_rst)
    i_acc_valid && i_acc_coil && i_acc_addr == COIL_BURNOUT_BASE
      |=> o_rsp_rdata[0] == $past(burnout_ff[0]);
  endproperty
  a_burnout_read: assert property (p_burnout_read) // [RULE_06]
    else $error("burnout coil read wrong");

  property p_coil_bit;
    @(posedge i_mclk) disable iff (i_rst)
    i_acc_valid && i_acc_coil |=> o_rsp_rdata[15:1] == 15'h0000;
  endproperty
  a_coil_bit: assert property (p_coil_bit) // [RULE_15]
    else $error("coil read not a single bit");

  property p_answer_time;
    @(posedge i_mclk) disable iff (i_rst)
    i_acc_valid |=> o_rsp_valid ##1 (o_rsp_valid == $past(i_acc_valid));
  endproperty
  a_answer_time: assert property (p_answer_time) // answer one cycle after access
    else $error("answer not one cycle after access");

  property p_restart_pulse;
    @(posedge i_mclk) disable iff (i_rst)
    i_acc_valid && i_acc_write && i_acc_coil && i_acc_addr == COIL_MAX_RST_BASE
      && i_acc_wdata[0] |=> max_pulse_ff[0] ##1 !max_pulse_ff[0] || $past(i_acc_valid);
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) // [RULE_04]
    else $error("max restart strobe missing");

endmodule : rtdm_map
`default_nettype wire

// >>> verilog/rtdm_tracker.sv
// historical max/min tracker and alarm compare for one entry
`timescale 1ns/1ps
`default_nettype none
module rtdm_tracker
  import rtdm_pkg::*;
(
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // link to the map
  rtdm_trk_if.trk   trk
);

  // ****************************************************************
  // maximum tracking
  // ****************************************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      trk.max_val <= MAX_RST;
    end else if (trk.restart_max) begin              // restart from current [RULE_04]
      trk.max_val <= trk.value;
    end else if (trk.sample && trk.value > trk.max_val) begin // [RULE_02]
      trk.max_val <= trk.value;
    end
  end

  // ****************************************************************
  // minimum tracking
  // ****************************************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      trk.min_val <= MIN_RST;
    end else if (trk.restart_min) begin              // restart from current [RULE_05]
      trk.min_val <= trk.value;
    end else if (trk.sample && trk.value < trk.min_val) begin // [RULE_03]
      trk.min_val <= trk.value;
    end
  end

  // ****************************************************************
  // alarm levels, follow the value every cycle
  // ****************************************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      trk.hi_alarm <= 1'b0;
      trk.lo_alarm <= 1'b0;
    end else begin
      trk.hi_alarm <= trk.value > trk.hi_thr;        // [RULE_07]
      trk.lo_alarm <= trk.value < trk.lo_thr;        // [RULE_08]
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_max_covers;
    @(posedge i_mclk) disable iff (i_rst)
    trk.sample && !trk.restart_max |=> trk.max_val >= $past(trk.value);
  endproperty
  a_max_covers: assert property (p_max_covers) // [RULE_02]
    else $error("max below sampled value");

  property p_min_covers;
    @(posedge i_mclk) disable iff (i_rst)
    trk.sample && !trk.restart_min |=> trk.min_val <= $past(trk.value);
  endproperty
  a_min_covers: assert property (p_min_covers) // [RULE_03]
    else $error("min above sampled value");

  property p_max_restart;
    @(posedge i_mclk) disable iff (i_rst)
    trk.restart_max |=> trk.max_val == $past(trk.value);
  endproperty
  a_max_restart: assert property (p_max_restart) // [RULE_04]
    else $error("max not restarted");

  property p_min_restart;
    @(posedge i_mclk) disable iff (i_rst)
    trk.restart_min |=> trk.min_val == $past(trk.value);
  endproperty
  a_min_restart: assert property (p_min_restart) // [RULE_05]
    else $error("min not restarted");

  property p_hi_alarm;
    @(posedge i_mclk) disable iff (i_rst)
    !i_rst |=> trk.hi_alarm == ($past(trk.value) > $past(trk.hi_thr));
  endproperty
  a_hi_alarm: assert property (p_hi_alarm) // [RULE_07]
    else $error("high alarm wrong");

  property p_lo_alarm;
    @(posedge i_mclk) disable iff (i_rst)
    !i_rst |=> trk.lo_alarm == ($past(trk.value) < $past(trk.lo_thr));
  endproperty
  a_lo_alarm: assert property (p_lo_alarm) // [RULE_08]
    else $error("low alarm wrong");

endmodule : rtdm_tracker
`default_nettype wire
